// >>> capture_timer_pkg.sv
// Shared constants, register indices and carriers for the capture buffer
// and modulus down-counter block.
// Assumes a 32-bit classic Wishbone bus with one register per word.
package capture_timer_pkg;

   localparam int ADDR_W  = 10;
   localparam int DATA_W  = 32;
   localparam int IDX_W   = 8;
   localparam int NCH     = 4;
   localparam int DELAY_W = 11;
   localparam int PRESC_W = 4;

   typedef logic [IDX_W-1:0] idx_t;

   // Register indices; byte address is four times the index
   localparam idx_t IDX_ACC_A_CTRL  = 8'ha0;
   localparam idx_t IDX_ACC_A_FLAGS = 8'ha1;
   localparam idx_t IDX_MOD_CTRL    = 8'ha6;
   localparam idx_t IDX_MOD_FLAGS   = 8'ha7;
   localparam idx_t IDX_ACC_EN      = 8'ha8;
   localparam idx_t IDX_DELAY       = 8'ha9;
   localparam idx_t IDX_OVW         = 8'haa;
   localparam idx_t IDX_SYS         = 8'hab;
   localparam idx_t IDX_MOD_COUNT   = 8'hac;
   localparam idx_t IDX_ACC_B_CTRL  = 8'hb0;
   localparam idx_t IDX_ACC_B_FLAGS = 8'hb1;
   localparam idx_t IDX_WIDE_A      = 8'hc0;
   localparam idx_t IDX_WIDE_B      = 8'hc1;
   // Per channel or per byte, element k serves channel or byte k
   localparam idx_t IDX_ACC_BYTE [NCH] = '{8'ha5, 8'ha4, 8'ha3, 8'ha2};
   localparam idx_t IDX_ACC_HOLD [NCH] = '{8'hb2, 8'hb3, 8'hb4, 8'hb5};
   localparam idx_t IDX_CAPTURE  [NCH] = '{8'h90, 8'h91, 8'h92, 8'h93};
   localparam idx_t IDX_CAP_HOLD [NCH] = '{8'hb8, 8'hb9, 8'hba, 8'hbb};

   // Field positions
   localparam int CASCADE_EN_BIT = 6;
   localparam int OVF_BIT        = 1;
   localparam int UF_BIT         = 7;

   // Reset and special values
   localparam logic [15:0] COUNT_PRESET = 16'hffff;
   localparam logic [15:0] COUNT_ZERO   = 16'h0000;
   localparam logic [15:0] COUNT_ONE    = 16'h0001;
   localparam logic [15:0] RST_WORD     = 16'h0000;

   // Prescaler terminal counts for division by 1, 4, 8 and 16
   localparam logic [PRESC_W-1:0] PRESC_LAST [4] =
      '{4'h0, 4'h3, 4'h7, 4'hf};
   // Filter delays in module clocks; code zero bypasses the filter
   localparam logic [DELAY_W-1:0] DELAY_CYC [4] =
      '{11'h000, 11'h100, 11'h200, 11'h400};

   typedef struct packed {
      logic       irq_en;
      logic       reload;
      logic       read_load;
      logic       force_latch;
      logic       force_load;
      logic       enable;
      logic [1:0] prescale;
   } mod_ctrl_s;

   typedef struct packed {
      logic [NCH-1:0] share;
      logic           flag_mode;
      logic           saturate;
      logic           buf_en;
      logic           latch_q;
   } sys_ctrl_s;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADDR_W-1:0] adr;
      logic [3:0]        sel;
      logic [DATA_W-1:0] dat;
   } wb_req_s;

endpackage

// >>> edge_delay_filter.sv
// Delay filter for one capture pin: passes a level change only if it
// still stands after the selected number of module clocks.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/10ps
module edge_delay_filter (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       pin_i,
   input  wire logic [1:0] delay_sel_i,
   output logic            level_o
);
   import capture_timer_pkg::*;

   typedef enum logic {F_IDLE, F_WAIT} filt_state_e;

   filt_state_e          state;
   logic [DELAY_W-1:0]   cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= F_IDLE;
         cnt     <= '0;
         level_o <= 1'b0;
      end else begin
         case (state)
            F_IDLE: begin
               if (delay_sel_i == 2'b00) begin
                  level_o <= pin_i;
               end else if (pin_i != level_o) begin
                  state <= F_WAIT;
                  cnt   <= DELAY_W'(1);
               end
            end
            F_WAIT: begin
               if (cnt >= DELAY_CYC[delay_sel_i]) begin
                  // Counter clears itself after each delay
                  state <= F_IDLE;
                  cnt   <= '0;
                  if (pin_i != level_o) begin
                     level_o <= pin_i;
                  end
               end else begin
                  cnt <= cnt + DELAY_W'(1);
               end
            end
            default: state <= F_IDLE;
         endcase
      end
   end

endmodule

// >>> byte_accumulator.sv
// One pulse accumulator byte with optional saturation, clear and load.
// Assumes the parent resolves cascading through inc_i and sat_i.
`timescale 1ns/10ps
module byte_accumulator #(
   parameter int W = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         inc_i,
   input  wire logic         sat_i,
   input  wire logic         clr_i,
   input  wire logic         wr_i,
   input  wire logic [W-1:0] wdat_i,
   output logic [W-1:0]      cnt_o,
   output logic              wrap_o
);
   logic at_max;

   assign at_max = &cnt_o;
   // Rollover seen by the cascade and the overflow flags
   assign wrap_o = inc_i & at_max & ~sat_i & ~wr_i & ~clr_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_o <= '0;
      end else if (wr_i) begin
         cnt_o <= wdat_i;
      end else if (clr_i) begin
         cnt_o <= '0;
      end else if (inc_i && !(at_max && sat_i)) begin
         cnt_o <= cnt_o + W'(1);
      end
   end

endmodule

// >>> capture_buffer_modulus_counter.sv
// Capture buffering, pulse accumulator bytes and modulus down-counter
// with a Wishbone register slave.
// Assumes pins, timer value and mode inputs are synchronous to REF_CLK_I.
`timescale 1ns/10ps
// Behaviour
// - Bytes three/two cascade; byte three wrap flags A
// - Bytes one/zero cascade; byte one wrap flags B
// - Modulus interrupt only when enabled and flagged
// - One-shot stops at zero; reload mode reloads
// - Count read gives live count or load
// - Force latch copies captures, clears uncascaded byte accumulators
// - Force load copies load value, resets prescaler
// - Disabled down-counter held at all ones
// - Prescale 1/4/8/16, new rate at load
// - Underflow flag set at zero, write-one clears
// - Fast clear: count access clears underflow flag
// - Read-only first-edge polarity bit per channel
// - Byte enables ignored while pair is cascaded
// - Delay filter 256/512/1024 clocks or bypass
// - Filter passes edge only if level changed
// - Overwrite protection until register is emptied
// - Channel sharing triggers partner channel too
// - Flag mode in queue: flag on holding load
// - Saturating bytes stop at maximum, else wrap
// - Holding registers work only when buffering enabled
// - Queue shifts capture to holding; latch events
module capture_buffer_modulus_counter (
   input  wire logic                            REF_CLK_I,
   input  wire logic                            RESET_I,
   input  wire capture_timer_pkg::wb_req_s      WB_I,
   output logic [capture_timer_pkg::DATA_W-1:0] WB_DAT_O,
   output logic                                 WB_ACK_O,
   input  wire logic [3:0]                      PIN_I,
   input  wire logic [3:0]                      RISE_EN_I,
   input  wire logic [3:0]                      FALL_EN_I,
   input  wire logic [15:0]                     TIMER_I,
   input  wire logic                            CASCADE_A_TICK_I,
   input  wire logic                            CASCADE_B_TICK_I,
   input  wire logic                            FAST_FLAG_CLEAR_I,
   input  wire logic                            NORMAL_MODE_INDICATOR_I,
   output logic [3:0]                           CAPTURE_FLAG_O,
   output logic                                 MOD_IRQ_O
);
   import capture_timer_pkg::*;

   logic                ack;
   logic [DATA_W-1:0]   rdat;
   idx_t                idx;
   logic                req, act, wr, rd, lane0, lane1;
   mod_ctrl_s           mctl, wmctl;
   sys_ctrl_s           sys;
   logic                sys_locked;
   logic [NCH-1:0]      novw, acc_en, pol, pol_arm;
   logic [1:0]          dly;
   logic                casc_a, casc_b, ovf_a, ovf_b, uf_flag;
   logic [NCH-1:0]      lvl, lvl_d, rise, fall, edge_ev, ev, ev_rise;
   logic [NCH-1:0]      acc_inc, acc_sat, acc_clr, acc_wr, acc_wrap;
   logic [7:0]          acc_wdat [NCH];
   logic [7:0]          acc [NCH];
   logic [7:0]          acc_hold [NCH];
   logic [15:0]         cap [NCH];
   logic [15:0]         hold [NCH];
   logic [NCH-1:0]      cap_full, hold_full, hold_ok, qf;
   logic [NCH-1:0]      q_load, cap_take, latch_take;
   logic                queue, latch_ev;
   logic [15:0]         count, load, wcount;
   logic [PRESC_W-1:0]  presc;
   logic [1:0]          rate;
   logic                tick, count_wr, direct_wr, force_load;
   logic                uf_set, zero_wr, force_latch;

   // Bus decode: effects happen on the edge where ack is high
   assign req   = WB_I.cyc & WB_I.stb;
   assign act   = req & ack;
   assign wr    = act & WB_I.we;
   assign rd    = act & ~WB_I.we;
   assign idx   = WB_I.adr[ADDR_W-1:2];
   assign lane0 = WB_I.sel[0];
   assign lane1 = WB_I.sel[1];
   assign wmctl = mod_ctrl_s'(WB_I.dat[7:0]);

   assign WB_ACK_O = ack;

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         ack      <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         ack <= req & ~ack;
         if (req && !ack) begin
            WB_DAT_O <= rdat;
         end
      end
   end

   // Input path: filter, edge detect, channel sharing
   for (genvar g = 0; g < NCH; g++) begin : g_chan
      localparam int P = g ^ 1;
      edge_delay_filter u_filt (
         .clk_i       (REF_CLK_I),
         .rst_i       (RESET_I),
         .pin_i       (PIN_I[g]),
         .delay_sel_i (dly),
         .level_o     (lvl[g])
      );
      assign ev[g]      = edge_ev[g] | (sys.share[g] & edge_ev[P]);
      assign ev_rise[g] = rise[g] | (sys.share[g] & rise[P]);
      byte_accumulator #(.W(8)) u_acc (
         .clk_i  (REF_CLK_I),
         .rst_i  (RESET_I),
         .inc_i  (acc_inc[g]),
         .sat_i  (acc_sat[g]),
         .clr_i  (acc_clr[g]),
         .wr_i   (acc_wr[g]),
         .wdat_i (acc_wdat[g]),
         .cnt_o  (acc[g]),
         .wrap_o (acc_wrap[g])
      );
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         lvl_d <= '0;
      end else begin
         lvl_d <= lvl;
      end
   end

   assign rise    = lvl & ~lvl_d & RISE_EN_I;
   assign fall    = ~lvl & lvl_d & FALL_EN_I;
   assign edge_ev = rise | fall;

   // Accumulator steering; a cascaded pair ignores its byte enables
   always_comb begin
      acc_inc[3] = casc_a ? acc_wrap[2] : ev[3] & acc_en[3];
      acc_inc[2] = casc_a ? CASCADE_A_TICK_I : ev[2] & acc_en[2];
      acc_inc[1] = casc_b ? acc_wrap[0] : ev[1] & acc_en[1];
      acc_inc[0] = casc_b ? CASCADE_B_TICK_I : ev[0] & acc_en[0];
      for (int k = 0; k < NCH; k++) begin
         acc_sat[k] = sys.saturate & ~((k >= 2) ? casc_a : casc_b);
         acc_clr[k] = latch_ev & ~((k >= 2) ? casc_a : casc_b);
         acc_wr[k]  = wr & lane0 & (idx == IDX_ACC_BYTE[k]);
         acc_wdat[k] = WB_I.dat[7:0];
         // Word access keeps both halves of a cascade coherent
         if (idx == ((k >= 2) ? IDX_WIDE_A : IDX_WIDE_B)) begin
            acc_wr[k] = wr & ((k % 2 == 1) ? lane1 : lane0);
            if (k % 2 == 1) begin
               acc_wdat[k] = WB_I.dat[15:8];
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         ovf_a <= 1'b0;
         ovf_b <= 1'b0;
      end else begin
         if ((wr && lane0 && idx == IDX_ACC_A_FLAGS && WB_I.dat[OVF_BIT])
             || (FAST_FLAG_CLEAR_I && act && (idx == IDX_ACC_BYTE[3] ||
                 idx == IDX_ACC_BYTE[2] || idx == IDX_WIDE_A))) begin
            ovf_a <= 1'b0;
         end
         if ((wr && lane0 && idx == IDX_ACC_B_FLAGS && WB_I.dat[OVF_BIT])
             || (FAST_FLAG_CLEAR_I && act && (idx == IDX_ACC_BYTE[1] ||
                 idx == IDX_ACC_BYTE[0] || idx == IDX_WIDE_B))) begin
            ovf_b <= 1'b0;
         end
         // A rollover in the clearing cycle is kept
         if (acc_wrap[3]) begin
            ovf_a <= 1'b1;
         end
         if (acc_wrap[1]) begin
            ovf_b <= 1'b1;
         end
      end
   end

   // Control registers
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         mctl       <= '0;
         sys        <= '0;
         sys_locked <= 1'b0;
         novw       <= '0;
         acc_en     <= '0;
         dly        <= '0;
         casc_a     <= 1'b0;
         casc_b     <= 1'b0;
      end else if (wr && lane0) begin
         case (idx)
            IDX_MOD_CTRL: begin
               mctl             <= wmctl;
               // Action bits are never stored, so they read zero
               mctl.force_latch <= 1'b0;
               mctl.force_load  <= 1'b0;
            end
            IDX_SYS: begin
               if (!NORMAL_MODE_INDICATOR_I || !sys_locked) begin
                  sys        <= sys_ctrl_s'(WB_I.dat[7:0]);
                  sys_locked <= 1'b1;
               end
            end
            IDX_OVW:        novw   <= WB_I.dat[NCH-1:0];
            IDX_ACC_EN:     acc_en <= WB_I.dat[NCH-1:0];
            IDX_DELAY:      dly    <= WB_I.dat[1:0];
            IDX_ACC_A_CTRL: casc_a <= WB_I.dat[CASCADE_EN_BIT];
            IDX_ACC_B_CTRL: casc_b <= WB_I.dat[CASCADE_EN_BIT];
            default: ;
         endcase
      end
   end

   // Modulus down-counter
   assign tick      = mctl.enable & (presc == PRESC_LAST[rate]);
   assign count_wr  = wr & (lane0 | lane1) & (idx == IDX_MOD_COUNT);
   assign wcount    = {lane1 ? WB_I.dat[15:8] : load[15:8],
                       lane0 ? WB_I.dat[7:0] : load[7:0]};
   assign direct_wr = count_wr & ~mctl.reload;
   assign force_load = wr & lane0 & (idx == IDX_MOD_CTRL) &
                       wmctl.force_load & mctl.enable;
   assign uf_set    = tick & ~direct_wr & ~force_load &
                      (count == COUNT_ONE);
   // With the counter enabled and not reloading, a zero write parks it at zero with no flag
   assign zero_wr   = count_wr & (wcount == COUNT_ZERO);
   assign force_latch = wr & lane0 & (idx == IDX_MOD_CTRL) &
                        wmctl.force_latch;
   assign latch_ev  = sys.buf_en & sys.latch_q &
                      (force_latch | uf_set | zero_wr);

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         load <= RST_WORD;
      end else if (count_wr) begin
         load <= wcount;
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         count <= COUNT_PRESET;
         presc <= '0;
         rate  <= '0;
      end else if (!mctl.enable) begin
         count <= COUNT_PRESET;
         presc <= '0;
      end else if (direct_wr) begin
         count <= wcount;
         presc <= '0;
         rate  <= mctl.prescale;
      end else if (force_load) begin
         count <= load;
         presc <= '0;
         rate  <= mctl.prescale;
      end else if (tick) begin
         presc <= '0;
         if (count == COUNT_ONE && mctl.reload) begin
            count <= load;
            rate  <= mctl.prescale;
         end else if (count != COUNT_ZERO) begin
            count <= count - COUNT_ONE;
         end
      end else begin
         presc <= presc + PRESC_W'(1);
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         uf_flag <= 1'b0;
      end else begin
         if ((wr && lane0 && idx == IDX_MOD_FLAGS && WB_I.dat[UF_BIT]) ||
             (FAST_FLAG_CLEAR_I && act && idx == IDX_MOD_COUNT)) begin
            uf_flag <= 1'b0;
         end
         if (uf_set) begin
            uf_flag <= 1'b1;
         end
      end
   end

   assign MOD_IRQ_O = mctl.irq_en & uf_flag;

   // Capture and holding registers
   assign queue      = sys.buf_en & ~sys.latch_q;
   assign hold_ok    = ~novw | ~hold_full;
   assign qf         = {NCH{queue}} & (cap_full | ~novw);
   assign q_load     = ev & qf & hold_ok;
   assign cap_take   = ev & ((qf & hold_ok) |
                             (~qf & (~novw | ~cap_full)));
   assign latch_take = {NCH{latch_ev}} & hold_ok;

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         cap_full  <= '0;
         hold_full <= '0;
         for (int i = 0; i < NCH; i++) begin
            cap[i]      <= RST_WORD;
            hold[i]     <= RST_WORD;
            acc_hold[i] <= '0;
         end
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (rd && idx == IDX_CAPTURE[i]) begin
               cap_full[i] <= 1'b0;
            end
            if (rd && idx == IDX_CAP_HOLD[i]) begin
               hold_full[i] <= 1'b0;
            end
            if (latch_take[i]) begin
               hold[i]      <= cap[i];
               acc_hold[i]  <= acc[i];
               hold_full[i] <= 1'b1;
               cap_full[i]  <= 1'b0;
            end
            if (q_load[i]) begin
               hold[i]      <= cap[i];
               hold_full[i] <= 1'b1;
            end
            if (cap_take[i]) begin
               cap[i]      <= TIMER_I;
               cap_full[i] <= 1'b1;
            end
         end
      end
   end

   // Polarity of the first capture after the holding register is read
   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         pol     <= '0;
         pol_arm <= '1;
      end else begin
         for (int i = 0; i < NCH; i++) begin
            if (rd && idx == IDX_CAP_HOLD[i]) begin
               pol_arm[i] <= 1'b1;
            end
            if (ev[i] && pol_arm[i]) begin
               pol[i]     <= ev_rise[i];
               pol_arm[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         CAPTURE_FLAG_O <= '0;
      end else if (sys.flag_mode && queue) begin
         CAPTURE_FLAG_O <= q_load;
      end else begin
         CAPTURE_FLAG_O <= ev;
      end
   end

   // Read multiplexer; polarity bits ignore writes
   always_comb begin
      rdat = '0;
      case (idx)
         IDX_MOD_CTRL:    rdat[7:0] = mctl;
         IDX_MOD_FLAGS: begin
            rdat[UF_BIT]    = uf_flag;
            rdat[NCH-1:0]   = pol;
         end
         IDX_ACC_EN:      rdat[NCH-1:0] = acc_en;
         IDX_DELAY:       rdat[1:0] = dly;
         IDX_OVW:         rdat[NCH-1:0] = novw;
         IDX_SYS:         rdat[7:0] = sys;
         IDX_MOD_COUNT:   rdat[15:0] = mctl.read_load ? load : count;
         IDX_ACC_A_CTRL:  rdat[CASCADE_EN_BIT] = casc_a;
         IDX_ACC_B_CTRL:  rdat[CASCADE_EN_BIT] = casc_b;
         IDX_ACC_A_FLAGS: rdat[OVF_BIT] = ovf_a;
         IDX_ACC_B_FLAGS: rdat[OVF_BIT] = ovf_b;
         IDX_WIDE_A:      rdat[15:0] = {acc[3], acc[2]};
         IDX_WIDE_B:      rdat[15:0] = {acc[1], acc[0]};
         default: ;
      endcase
      for (int i = 0; i < NCH; i++) begin
         if (idx == IDX_CAPTURE[i]) begin
            rdat[15:0] = cap[i];
         end
         if (idx == IDX_CAP_HOLD[i]) begin
            rdat[15:0] = hold[i];
         end
         if (idx == IDX_ACC_BYTE[i]) begin
            rdat[7:0] = acc[i];
         end
         if (idx == IDX_ACC_HOLD[i]) begin
            rdat[7:0] = acc_hold[i];
         end
      end
   end

endmodule

// >>> capture_buffer_modulus_counter_sva.sv
// Assertions on the register bus and interrupt of the capture block.
// Bound to the top module; sees its ports only.
`timescale 1ns/10ps
module capture_buffer_modulus_counter_sva (
   input wire logic                                 REF_CLK_I,
   input wire logic                                 RESET_I,
   input wire capture_timer_pkg::wb_req_s           WB_I,
   input wire logic [capture_timer_pkg::DATA_W-1:0] WB_DAT_O,
   input wire logic                                 WB_ACK_O,
   input wire logic                                 FAST_FLAG_CLEAR_I,
   input wire logic [3:0]                           CAPTURE_FLAG_O,
   input wire logic                                 MOD_IRQ_O
);
   import capture_timer_pkg::*;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   sequence s_rd(i);
      WB_I.cyc && WB_I.stb && !WB_I.we && WB_I.adr[9:2] == i ##1 WB_ACK_O;
   endsequence
   sequence s_wr(i);
      WB_ACK_O && WB_I.we && WB_I.adr[9:2] == i;
   endsequence
   property p_ack_next;
      $rose(WB_I.cyc && WB_I.stb) |=> WB_ACK_O;
   endproperty
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   property p_ack_cause;
      WB_ACK_O |-> $past(WB_I.cyc && WB_I.stb);
   endproperty
   property p_rst_quiet;
      $fell(RESET_I) |-> !WB_ACK_O && CAPTURE_FLAG_O == 4'h0 && !MOD_IRQ_O;
   endproperty
   property p_unmapped;
      s_rd(8'h00) |-> WB_DAT_O == '0;
   endproperty
   property p_ctrl_strobes;
      s_rd(IDX_MOD_CTRL) |-> WB_DAT_O[4:3] == 2'b00;
   endproperty
   property p_irq_fall;
      $fell(MOD_IRQ_O) |-> $past(WB_ACK_O);
   endproperty
   property p_uf_clear;
      s_wr(IDX_MOD_FLAGS) ##0 WB_I.dat[UF_BIT] |=> !MOD_IRQ_O;
   endproperty
   property p_fast_clear;
      s_wr(IDX_MOD_COUNT) ##0 FAST_FLAG_CLEAR_I |=> !MOD_IRQ_O;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack late");
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack too long");
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs busy after reset");
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   a_ctrl_strobes: assert property (p_ctrl_strobes)
      else $error("strobe bits read back");
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq dropped on its own");
   a_uf_clear: assert property (p_uf_clear)
      else $error("underflow not cleared");
   a_fast_clear: assert property (p_fast_clear)
      else $error("fast clear missed");
endmodule
bind capture_buffer_modulus_counter capture_buffer_modulus_counter_sva
   capture_buffer_modulus_counter_sva_inst (.REF_CLK_I, .RESET_I, .WB_I,
   .WB_DAT_O, .WB_ACK_O, .FAST_FLAG_CLEAR_I, .CAPTURE_FLAG_O, .MOD_IRQ_O);

// >>> cpu_bus_model.sv
// CPU side of the register bus: classic single Wishbone cycles.
// Assumes the slave answers each request with an ack.
`timescale 1ns/10ps
module cpu_bus_model (
   input  wire logic                  clk_i,
   input  wire logic                  ack_i,
   output capture_timer_pkg::wb_req_s req_o
);
   import capture_timer_pkg::*;
   initial req_o = '0;
   // Whole-word cycles only, so a wide register never tears
   task automatic access(input logic we, input idx_t idx,
                         input logic [15:0] dat);
      @(posedge clk_i);
      req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                 sel: 4'hf, dat: {16'h0000, dat}};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      req_o <= '0;
      @(posedge clk_i);
   endtask
endmodule

// >>> capture_buffer_modulus_counter_tb_top.sv
// Self-checking bench for the capture buffer and modulus counter.
// Assumes the CPU bus model drives every register cycle.
`timescale 1ns/10ps
module capture_buffer_modulus_counter_tb_top;
   import capture_timer_pkg::*;
   logic        ref_clk, reset, ack, irq, fast, tick_a, tick_b, normal;
   logic [3:0]  pin, flag;
   logic [15:0] timer;
   logic [31:0] rdat;
   wb_req_s     req;
   int          num_errors, num_checks, nflag, seed;
   logic [15:0] exp_q[$];
   logic [15:0] tv[2];

   capture_buffer_modulus_counter capture_buffer_modulus_counter_inst (
      .REF_CLK_I(ref_clk), .RESET_I(reset), .WB_I(req), .WB_DAT_O(rdat),
      .WB_ACK_O(ack), .PIN_I(pin), .RISE_EN_I(4'hf), .FALL_EN_I(4'h0),
      .TIMER_I(timer), .CASCADE_A_TICK_I(tick_a), .CASCADE_B_TICK_I(tick_b),
      .FAST_FLAG_CLEAR_I(fast), .NORMAL_MODE_INDICATOR_I(normal),
      .CAPTURE_FLAG_O(flag), .MOD_IRQ_O(irq));
   cpu_bus_model cpu_bus_model_inst (.clk_i(ref_clk), .ack_i(ack),
      .req_o(req));

   task automatic fail(input string msg);
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
         fail($sformatf("got %h want %h", got, exp));
   endtask
   task automatic wr(input idx_t i, input logic [15:0] d);
      cpu_bus_model_inst.access(1'b1, i, d);
   endtask
   task automatic rd(input idx_t i, input logic [15:0] e);
      exp_q.push_back(e);
      cpu_bus_model_inst.access(1'b0, i, 16'h0000);
   endtask
   // Rising edge on channel 0 with a fresh timer value held around it
   task automatic rise0();
      @(posedge ref_clk);
      tv[0] = tv[1];
      tv[1] = 16'($random(seed));
      timer <= tv[1];
      @(posedge ref_clk) pin[0] <= 1'b1;
      repeat (8) @(posedge ref_clk);
      pin[0] <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", num_errors, num_checks);
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      if (flag[0] === 1'b1)
         nflag++;
      if (ack === 1'b1 && req.we === 1'b0) begin
         if (exp_q.size() == 0)
            fail("read with no expectation");
         else
            chk(rdat[15:0], exp_q.pop_front());
      end
   end
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail("timeout");
      end_sim();
   end

   initial begin
      seed = 86767;
      reset = 1'b1;
      pin = 4'h0;
      timer = 16'h0000;
      {normal, fast, tick_a, tick_b} = 4'h0;
      tv = '{default: 16'h0000};
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      rd(IDX_MOD_COUNT, COUNT_PRESET);
      rd(8'h00, 16'h0000);
      wr(IDX_MOD_CTRL, 16'h0004);
      wr(IDX_MOD_COUNT, 16'h0005);
      repeat (10) @(posedge ref_clk);
      rd(IDX_MOD_COUNT, COUNT_ZERO);
      rd(IDX_MOD_FLAGS, 16'h0080);
      wr(IDX_MOD_CTRL, 16'h0084);
      chk(16'(irq), 16'h0001);
      wr(IDX_MOD_FLAGS, 16'h0000);
      chk(16'(irq), 16'h0001);
      wr(IDX_MOD_FLAGS, 16'h0080);
      chk(16'(irq), 16'h0000);
      // Divide by 16 only from the count write onwards
      wr(IDX_MOD_CTRL, 16'h0007);
      wr(IDX_MOD_COUNT, 16'h0003);
      rd(IDX_MOD_COUNT, 16'h0003);
      repeat (60) @(posedge ref_clk);
      rd(IDX_MOD_COUNT, COUNT_ZERO);
      wr(IDX_MOD_CTRL, 16'h0000);
      wr(IDX_MOD_CTRL, 16'h0067);
      wr(IDX_MOD_COUNT, 16'h0040);
      rd(IDX_MOD_COUNT, 16'h0040);
      wr(IDX_MOD_CTRL, 16'h00cf);
      rd(IDX_MOD_COUNT, 16'h0040);
      rd(IDX_MOD_CTRL, 16'h00c7);
      wr(IDX_MOD_FLAGS, 16'h0080);
      repeat (1100) @(posedge ref_clk);
      rd(IDX_MOD_FLAGS, 16'h0080);
      chk(16'(irq), 16'h0001);
      fast <= 1'b1;
      wr(IDX_MOD_COUNT, 16'h0040);
      fast <= 1'b0;
      rd(IDX_MOD_FLAGS, 16'h0000);
      wr(IDX_MOD_CTRL, 16'h0000);
      rd(IDX_MOD_COUNT, COUNT_PRESET);
      for (int p = 0; p < 2; p++) begin
         wr(p ? IDX_ACC_B_CTRL : IDX_ACC_A_CTRL, 16'h0040);
         wr(p ? IDX_WIDE_B : IDX_WIDE_A, 16'hffff);
         {tick_b, tick_a} <= p ? 2'b10 : 2'b01;
         @(posedge ref_clk) {tick_b, tick_a} <= 2'b00;
         rd(p ? IDX_WIDE_B : IDX_WIDE_A, 16'h0000);
         rd(p ? IDX_ACC_B_FLAGS : IDX_ACC_A_FLAGS, 16'h0002);
         wr(p ? IDX_ACC_B_CTRL : IDX_ACC_A_CTRL, 16'h0000);
      end
      wr(IDX_SYS, 16'h0006);
      wr(IDX_ACC_EN, 16'h0001);
      for (int s = 0; s < 2; s++) begin
         wr(IDX_ACC_BYTE[0], 16'h00fe);
         repeat (3) rise0();
         if (s == 0)
            rd(IDX_MOD_FLAGS, 16'h0001);
         rd(IDX_CAPTURE[0], tv[1]);
         rd(IDX_CAP_HOLD[0], tv[0]);
         rd(IDX_ACC_BYTE[0], s ? 16'h0001 : 16'h00ff);
         wr(IDX_SYS, 16'h0002);
      end
      wr(IDX_SYS, 16'h0003);
      normal <= 1'b1;
      wr(IDX_SYS, 16'h0000);
      rd(IDX_SYS, 16'h0003);
      wr(IDX_MOD_CTRL, 16'h0010);
      rd(IDX_CAP_HOLD[0], tv[1]);
      rd(IDX_ACC_BYTE[0], 16'h0000);
      rd(IDX_ACC_HOLD[0], 16'h0001);
      wr(IDX_DELAY, 16'h0001);
      @(posedge ref_clk) pin[0] <= 1'b1;
      repeat (20) @(posedge ref_clk);
      pin[0] <= 1'b0;
      repeat (300) @(posedge ref_clk);
      chk(16'(nflag), 16'h0006);
      pin[0] <= 1'b1;
      repeat (250) @(posedge ref_clk);
      chk(16'(nflag), 16'h0006);
      repeat (20) @(posedge ref_clk);
      chk(16'(nflag), 16'h0007);
      end_sim();
   end
endmodule
